//--- bench/rcd_pin_rx.sv
// far-side model: receiver measuring the period of the reference clock pin
module rcd_pin_rx (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic pin_o,
    input wire logic pin_oe,
    output logic [15:0] period_r
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_r;
    logic lvl;
    logic lvl_r;
    logic [15:0] cnt_r;
    // undriven pin has no pull, so show the inverse of the last driven level
    assign lvl = pin_oe ? pin_o : ~last_r;
    // cycles between two rising edges seen on the wire
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            last_r <= 1'h0;
            lvl_r <= 1'h0;
            cnt_r <= 16'h0000;
            period_r <= 16'h0000;
        end else begin
            if (pin_oe) last_r <= pin_o;
            lvl_r <= lvl;
            cnt_r <= cnt_r + 16'h0001;
            if (lvl && !lvl_r) begin
                period_r <= cnt_r + 16'h0001;
                cnt_r <= 16'h0000;
            end
        end
    end
endmodule : rcd_pin_rx

//--- bench/rcd_top_properties.sv
// checker: bus timing and register read rules at the ports of rcd_top
module rcd_top_properties
    import rcd_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic reference_clock_out_pin_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_write_resp_time: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
    a_read_resp_time: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data dropped");
    a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    a_unused_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31] == 1'h0
        && s_axi_rdata[14] == 1'h0 && s_axi_rdata[10] == 1'h0 && s_axi_rdata[7:4] == 4'h0)
        else $error("unused bits not zero");
    a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[ADDR_W-1:2]
        != '0 |=> s_axi_rresp == RCD_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_mapped_okay: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[ADDR_W-1:2]
        == '0 |=> s_axi_rresp == RCD_RESP_OKAY) else $error("mapped read refused");
    a_reset_quiet: assert property ($rose(rst_n) |-> !reference_clock_out_pin_oe
        && !s_axi_bvalid && !s_axi_rvalid) else $error("outputs active after reset");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_pin_on: cover property ($rose(reference_clock_out_pin_oe));
endmodule : rcd_top_properties

bind rcd_top rcd_top_properties #(.ADDR_W(ADDR_W)) i_rcd_top_properties (
    .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .reference_clock_out_pin_oe(reference_clock_out_pin_oe));

//--- bench/reference_clock_divider_bench.sv
// testbench: register accesses, power states and pin period of the clock divider
module reference_clock_divider_bench
    import rcd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, chip_idle, chip_sleep, pin_o, pin_oe;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs;
    logic [1:0] src_cnt;
    logic [15:0] source_clocks, period;
    int error_cnt, n_compared, cyc;

    rcd_top i_rcd_top (.ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .source_clocks(source_clocks), .chip_idle(chip_idle), .chip_sleep(chip_sleep),
        .reference_clock_out_pin_o(pin_o), .reference_clock_out_pin_oe(pin_oe));
    rcd_pin_rx i_rcd_pin_rx (.ref_clk(ref_clk), .rst_n(rst_n), .pin_o(pin_o),
        .pin_oe(pin_oe), .period_r(period));

    // 20 MHz clock
    initial begin
        ref_clk = 1'h0;
        forever #25 ref_clk = ~ref_clk;
    end

    // every source toggles each 4 cycles, well below half the bus clock
    always @(posedge ref_clk) begin
        src_cnt <= src_cnt + 2'h1;
        if (src_cnt == 2'h3) source_clocks <= ~source_clocks;
    end

    // hang guard, the whole run needs far fewer cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // write with address and data offered together, each released when taken
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d);
        logic aw_done;
        logic w_done;
        aw_done = 1'h0;
        w_done = 1'h0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!(aw_done && w_done)) begin
            @(posedge ref_clk);
            if (!aw_done && awready) begin
                aw_done = 1'h1;
                awvalid <= 1'h0;
            end
            if (!w_done && wready) begin
                w_done = 1'h1;
                wvalid <= 1'h0;
            end
        end
        do @(posedge ref_clk); while (bvalid !== 1'h1);
        rs = bresp;
        bready <= 1'h0;
    endtask : axi_write

    task automatic axi_read(input logic [11:0] a);
        @(posedge ref_clk); // a previous read lowered rready in this step
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge ref_clk); while (arready !== 1'h1);
        arvalid <= 1'h0;
        do @(posedge ref_clk); while (rvalid !== 1'h1);
        rd = rdata;
        rs = rresp;
        rready <= 1'h0;
    endtask : axi_read

    // write a control word, wait, then read it back against the expected image
    task automatic wr_rd(input logic [31:0] d, input logic [31:0] exp);
        axi_write(RCD_CTRL_ADDR, d);
        check({30'h0, rs}, {30'h0, RCD_RESP_OKAY});
        repeat (8) @(posedge ref_clk);
        axi_read(RCD_CTRL_ADDR);
        check(rd, exp);
    endtask : wr_rd

    initial begin
        {awvalid, wvalid, bready, arvalid, rready, chip_idle, chip_sleep} = 7'h00;
        awaddr = 12'h000;
        araddr = 12'h000;
        wdata = 32'h0;
        wstrb = 4'hF;
        src_cnt = 2'h0;
        source_clocks = 16'h5555;
        error_cnt = 0;
        n_compared = 0;
        cyc = 0;
        rst_n = 1'h0;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'h1;
        repeat (2) @(posedge ref_clk);
        axi_read(RCD_CTRL_ADDR);
        check(rd, 32'h0);
        check({31'h0, pin_oe}, 32'h0);
        // every writable bit set except enable and switch, unused bits stay zero
        wr_rd(32'hFFFF_7DFF, 32'h7FFF_380F);
        check({31'h0, pin_oe}, 32'h0);
        // unmapped word: write ignored, read returns zero, both refused
        axi_write(12'h004, 32'hFFFF_FFFF);
        check({30'h0, rs}, {30'h0, RCD_RESP_SLVERR});
        axi_read(12'h004);
        check({30'h0, rs}, {30'h0, RCD_RESP_SLVERR});
        check(rd, 32'h0);
        // enable bypass on source 2, pin follows the source
        wr_rd(32'h0000_9002, 32'h0000_9102);
        check({31'h0, pin_oe}, 32'h1);
        repeat (30) @(posedge ref_clk);
        check({16'h0, period}, 32'h8);
        // halted in idle: new divide value waits for the switch
        chip_idle <= 1'h1;
        wstrb <= 4'h2;
        wr_rd(32'h0000_B000, 32'h0000_B002);
        wstrb <= 4'hF;
        wr_rd(32'h0002_B002, 32'h0002_B002);
        check({31'h0, pin_o}, 32'h0);
        chip_idle <= 1'h0;
        repeat (30) @(posedge ref_clk);
        check({16'h0, period}, 32'h8);
        wstrb <= 4'h2;
        axi_write(RCD_CTRL_ADDR, 32'h0000_9200);
        rd = 32'h0000_0200;
        for (int i = 0; i < 20 && rd[RCD_SW_BIT]; i++) axi_read(RCD_CTRL_ADDR);
        check(rd, 32'h0002_9102);
        repeat (80) @(posedge ref_clk);
        check({16'h0, period}, 32'h20);
        // sleep: run when asked, except on the two lowest sources
        wr_rd(32'h0000_9800, 32'h0002_9902);
        chip_sleep <= 1'h1;
        wr_rd(32'h0000_9800, 32'h0002_9902);
        wr_rd(32'h0000_9000, 32'h0002_9002);
        wstrb <= 4'hF;
        wr_rd(32'h0002_9801, 32'h0002_9801);
        wr_rd(32'h0002_9800, 32'h0002_9800);
        // disable drops the pin drive
        wr_rd(32'h0000_0000, 32'h0000_0000);
        chip_sleep <= 1'h0;
        check({31'h0, pin_oe}, 32'h0);
        print_verdict();
    end
endmodule : reference_clock_divider_bench

//--- hw/rcd_divider.sv
// module: counts rising edges of the chosen source and toggles the divided clock
module rcd_divider
    import rcd_pkg::*;
#(
    parameter int DIV_W = RCD_DIV_W
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic src_lvl,
    input wire logic run,
    input wire logic [DIV_W-1:0] divisor,
    output logic div_clk_r,
    output logic wrap_r
);

    logic src_prev_r;
    logic [DIV_W-1:0] cnt_r;
    logic src_rise;

    assign src_rise = src_lvl & ~src_prev_r;

    // previous source level for edge detection
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            src_prev_r <= 1'b0;
        end else begin
            src_prev_r <= src_lvl;
        end
    end

    // divisor zero passes the source; otherwise half period is divisor source edges
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !run) begin
            cnt_r <= '0;
            div_clk_r <= 1'b0;
            wrap_r <= 1'b0;
        end else if (divisor == '0) begin
            cnt_r <= '0;
            div_clk_r <= src_lvl;
            wrap_r <= src_rise;
        end else if (src_rise) begin
            if (cnt_r == divisor - DIV_W'(1)) begin
                cnt_r <= '0;
                div_clk_r <= ~div_clk_r;
                wrap_r <= 1'b1; // safe point to swap divisor
            end else begin
                cnt_r <= cnt_r + DIV_W'(1);
                wrap_r <= 1'b0;
            end
        end else begin
            wrap_r <= 1'b0;
        end
    end

endmodule : rcd_divider

//--- hw/rcd_pkg.sv
// package: register layout, reset values, states and carriers of the reference clock divider
package rcd_pkg;

    // register map, byte address on the bus
    localparam logic [11:0] RCD_CTRL_ADDR = 12'h000;

    // field positions inside the control word
    localparam int RCD_DIV_LSB = 16;
    localparam int RCD_DIV_MSB = 30;
    localparam int RCD_ON_BIT = 15;
    localparam int RCD_HALT_BIT = 13;
    localparam int RCD_OE_BIT = 12;
    localparam int RCD_KEEP_BIT = 11;
    localparam int RCD_SW_BIT = 9;
    localparam int RCD_ACT_BIT = 8;
    localparam int RCD_SEL_MSB = 3;

    // field widths and number of selectable sources
    localparam int RCD_DIV_W = 15;
    localparam int RCD_SEL_W = 4;
    localparam int RCD_SRC_N = 16;

    // values after reset
    localparam logic [14:0] RCD_DIV_RST = 15'h0000;
    localparam logic [3:0] RCD_SEL_RST = 4'h0;

    // highest source encoding for which keep-running-asleep is ignored
    localparam logic [3:0] RCD_SEL_NO_KEEP = 4'h1;

    // bus answers
    localparam logic [1:0] RCD_RESP_OKAY = 2'h0;
    localparam logic [1:0] RCD_RESP_SLVERR = 2'h2;

    // writable control fields, as software last wrote them
    typedef struct packed {
        logic [14:0] clock_divide_value;
        logic enable;
        logic halt_when_idle;
        logic out_enable;
        logic keep_running_asleep;
        logic [3:0] source_clock_select;
    } rcd_ctrl_t;

    localparam rcd_ctrl_t RCD_CTRL_RST = rcd_ctrl_t'(23'h000000);

    // one write beat held by the bus slave
    typedef struct packed {
        logic [31:0] data;
        logic [3:0] strb;
    } rcd_wbeat_t;

    // divider switch sequence
    typedef enum logic [2:0] {
        RCD_SW_IDLE = 3'h1,
        RCD_SW_WAIT = 3'h2,
        RCD_SW_LOAD = 3'h4
    } rcd_sw_state_t;

endpackage : rcd_pkg

//--- hw/rcd_sync.sv
// module: two-stage synchroniser for levels arriving from other clock domains
module rcd_sync
    import rcd_pkg::*;
#(
    parameter int W = RCD_SRC_N
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_r
);

    logic [W-1:0] meta_r;

    // first stage feeds only the second one
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

endmodule : rcd_sync

//--- hw/rcd_top.sv
// module: reference clock divider with control register on an AXI4-Lite slave
//
// What this block does
// R1: a 15-bit divide value in bits 30..16 sets division of the source clock
// R2: enable bit 15 runs the generator when one, disables it when zero
// R3: bit 13 set halts the generator while the chip idles; clear keeps it running
// R4: bit 12 set drives the divided clock onto the output pin, clear does not; the pin also stays undriven while bit 15 is zero
// R5: bit 11 set keeps the output running in sleep, clear stops it
// R6: keep-running-asleep is ignored when source select is 0000 or 0001
// R7: switch bit 9 reads one while a divider change is pending, hardware clears it
// R8: while enabled, a new divide value waits until software sets the switch bit
// R9: read-only bit 8 shows whether a reference clock request is active
// R10: software must not change source or divide value while bit 8 reads one
// R11: bits 31, 14, 10 and 7..4 always read as zero
// R12: source select in bits 3..0 chooses the clock feeding the divider
// R13: all fields reset to zero, generator off and pin undriven
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
module rcd_top
    import rcd_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int SRC_N = RCD_SRC_N
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // candidate source clocks, asynchronous to ref_clk
    input wire logic [SRC_N-1:0] source_clocks,
    // chip power state from the power controller, same domain
    input wire logic chip_idle,
    input wire logic chip_sleep,
    // output clock pin
    output logic reference_clock_out_pin_o,
    output logic reference_clock_out_pin_oe
);

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    rcd_ctrl_t ctrl_r;
    logic [RCD_DIV_W-1:0] active_div_r;
    logic divider_switch_request_r;
    logic active_r;
    rcd_sw_state_t sw_state_r;

    // bus slave state
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic aw_held_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic w_held_r;
    rcd_wbeat_t w_beat_r;
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    // pin flops
    logic pin_val_r;
    logic pin_oe_r;

    // combinational helpers
    logic wr_go;
    logic wr_hit;
    logic [31:0] wr_val;
    logic sw_set;
    logic [31:0] ctrl_image;
    logic keep_eff;
    logic run;
    logic [SRC_N-1:0] src_sync;
    logic src_lvl;
    logic div_clk;
    logic div_wrap;

    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------

    // word-aligned decode; low two address bits are ignored
    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr);
        addr_hit = (addr[ADDR_W-1:2] == RCD_CTRL_ADDR[ADDR_W-1:2]);
    endfunction : addr_hit

    // apply byte enables to a word
    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old_w,
        input logic [31:0] new_w,
        input logic [3:0] strb
    );
        logic [31:0] m;
        m = old_w;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                m[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        merge_bytes = m;
    endfunction : merge_bytes

    // ------------------------------------------------------------------
    // read image of the control register
    // ------------------------------------------------------------------

    // unimplemented bits are tied low here, not stored
    always_comb begin
        ctrl_image = '0; // see R11
        ctrl_image[RCD_DIV_MSB:RCD_DIV_LSB] = ctrl_r.clock_divide_value;
        ctrl_image[RCD_ON_BIT] = ctrl_r.enable;
        ctrl_image[RCD_HALT_BIT] = ctrl_r.halt_when_idle;
        ctrl_image[RCD_OE_BIT] = ctrl_r.out_enable;
        ctrl_image[RCD_KEEP_BIT] = ctrl_r.keep_running_asleep;
        ctrl_image[RCD_SW_BIT] = divider_switch_request_r; // see R7
        ctrl_image[RCD_ACT_BIT] = active_r; // see R9
        ctrl_image[RCD_SEL_MSB:0] = ctrl_r.source_clock_select;
    end

    // ------------------------------------------------------------------
    // AXI4-Lite write path: address and data taken in either order
    // ------------------------------------------------------------------
    assign wr_go = aw_held_r & w_held_r & ~bvalid_r;
    assign wr_hit = wr_go & addr_hit(aw_addr_r);
    assign wr_val = merge_bytes(ctrl_image, w_beat_r.data, w_beat_r.strb);
    // a one in the switch bit sets the request; a zero leaves it alone
    assign sw_set = wr_hit & w_beat_r.strb[1] & w_beat_r.data[RCD_SW_BIT];

    // write address channel
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            awready_r <= 1'b0;
            aw_held_r <= 1'b0;
            aw_addr_r <= '0;
        end else begin
            if (s_axi_awvalid && awready_r) begin
                awready_r <= 1'b0;
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end else begin
                if (wr_go) begin
                    aw_held_r <= 1'b0;
                end
                if (!aw_held_r && !bvalid_r) begin
                    awready_r <= 1'b1;
                end
            end
        end
    end

    // write data channel
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wready_r <= 1'b0;
            w_held_r <= 1'b0;
            w_beat_r <= '0;
        end else begin
            if (s_axi_wvalid && wready_r) begin
                wready_r <= 1'b0;
                w_held_r <= 1'b1;
                w_beat_r.data <= s_axi_wdata;
                w_beat_r.strb <= s_axi_wstrb;
            end else begin
                if (wr_go) begin
                    w_held_r <= 1'b0;
                end
                if (!w_held_r && !bvalid_r) begin
                    wready_r <= 1'b1;
                end
            end
        end
    end

    // write response; unmapped addresses answer SLVERR and change nothing
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bvalid_r <= 1'b0;
            bresp_r <= RCD_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit ? RCD_RESP_OKAY : RCD_RESP_SLVERR;
        end else if (s_axi_bready && bvalid_r) begin
            bvalid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read path: data one cycle after the address is taken
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RCD_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && arready_r) begin
                arready_r <= 1'b0;
                rvalid_r <= 1'b1;
                // unmapped reads return zero with SLVERR
                rdata_r <= addr_hit(s_axi_araddr) ? ctrl_image : 32'h00000000;
                rresp_r <= addr_hit(s_axi_araddr) ? RCD_RESP_OKAY : RCD_RESP_SLVERR;
            end else if (s_axi_rready && rvalid_r) begin
                rvalid_r <= 1'b0;
            end else if (!rvalid_r) begin
                arready_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------------

    // software fields; everything clears on reset
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_r <= RCD_CTRL_RST; // see R13
        end else if (wr_hit) begin
            ctrl_r.clock_divide_value <= wr_val[RCD_DIV_MSB:RCD_DIV_LSB]; // see R1
            ctrl_r.enable <= wr_val[RCD_ON_BIT]; // see R2
            ctrl_r.halt_when_idle <= wr_val[RCD_HALT_BIT]; // see R3
            ctrl_r.out_enable <= wr_val[RCD_OE_BIT]; // see R4
            ctrl_r.keep_running_asleep <= wr_val[RCD_KEEP_BIT]; // see R5
            ctrl_r.source_clock_select <= wr_val[RCD_SEL_MSB:0]; // see R12
        end
    end

    // ------------------------------------------------------------------
    // divider switch: a new divide value reaches the counter only at a wrap or while the counter is stopped
    // so the pin never sees a runt half period
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sw_state_r <= RCD_SW_IDLE;
            divider_switch_request_r <= 1'b0;
            active_div_r <= RCD_DIV_RST;
        end else begin
            case (sw_state_r)
                RCD_SW_IDLE: begin
                    if (!ctrl_r.enable) begin
                        // disabled: value applies at once, also one being written now
                        active_div_r <= wr_hit ? wr_val[RCD_DIV_MSB:RCD_DIV_LSB]
                            : ctrl_r.clock_divide_value; // see R8
                    end
                    if (sw_set) begin
                        divider_switch_request_r <= 1'b1; // see R7
                        sw_state_r <= RCD_SW_WAIT;
                    end
                end
                RCD_SW_WAIT: begin
                    // halted counter has no edge to wait for
                    if (div_wrap || !run) begin
                        sw_state_r <= RCD_SW_LOAD;
                    end
                end
                RCD_SW_LOAD: begin
                    active_div_r <= ctrl_r.clock_divide_value; // see R8
                    // a request landing now wins over completion
                    if (sw_set) begin
                        sw_state_r <= RCD_SW_WAIT;
                    end else begin
                        divider_switch_request_r <= 1'b0; // see R7
                        sw_state_r <= RCD_SW_IDLE;
                    end
                end
                default: begin
                    sw_state_r <= RCD_SW_IDLE;
                    divider_switch_request_r <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // run conditions and source path
    // ------------------------------------------------------------------

    // low encodings are clocks that stop in sleep anyway
    assign keep_eff = ctrl_r.keep_running_asleep
        & (ctrl_r.source_clock_select > RCD_SEL_NO_KEEP); // see R6

    // enabled, not halted by idle, not stopped by sleep
    assign run = ctrl_r.enable // see R2
        & ~(ctrl_r.halt_when_idle & chip_idle) // see R3
        & ~(chip_sleep & ~keep_eff); // see R5

    // sources must stay below half of ref_clk to be seen by the edge detector
    rcd_sync #(
        .W(SRC_N)
    ) i_rcd_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .async_in(source_clocks),
        .sync_r(src_sync)
    );

    assign src_lvl = src_sync[ctrl_r.source_clock_select]; // see R12

    rcd_divider #(
        .DIV_W(RCD_DIV_W)
    ) i_rcd_divider (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .src_lvl(src_lvl),
        .run(run),
        .divisor(active_div_r), // see R1
        .div_clk_r(div_clk),
        .wrap_r(div_wrap)
    );

    // ------------------------------------------------------------------
    // request status and pin
    // ------------------------------------------------------------------

    // request is active while the generator is really running
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            active_r <= 1'b0;
        end else begin
            active_r <= run; // see R9
        end
    end

    // pin carries the clock only when enabled and output enabled
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pin_val_r <= 1'b0;
            pin_oe_r <= 1'b0; // see R13
        end else begin
            pin_oe_r <= ctrl_r.enable & ctrl_r.out_enable; // see R4
            pin_val_r <= ctrl_r.enable & ctrl_r.out_enable & div_clk; // see R4
        end
    end

    // outputs straight from flops
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign reference_clock_out_pin_o = pin_val_r;
    assign reference_clock_out_pin_oe = pin_oe_r;

endmodule : rcd_top
